//--- core/power_monitor_results.sv
`timescale 1ns/100ps
// Functional notes
// - Current result signed 16 bits at 7h
// - Bus voltage at 5h, never negative
// - Temperature 12-bit signed at 6h
// - Power 24-bit, energy/charge 40-bit at 8h/9h/Ah
// - Signed results in two's complement
// - Energy wraps to zero on overflow
// - Accumulator clear zeroes energy anytime
// - Charge overflow sets sticky status flag
// - Bus code reaches 102.4 V, unclamped
// - Eight selectable conversion times, 50 us fastest
// - Eight averaging counts; period is time times count
// - Serial read sends most significant byte first
// - Pointer kept until next pointer write
module power_monitor_results #(
  parameter int US_CYCLES = power_monitor_pkg::CYCLES_PER_US
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [2:0]  conv_sel,
  input  wire logic [2:0]  avg_sel,
  input  wire logic        accumulator_clear_bit,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_current,
  input  wire logic [15:0] sample_bus,
  input  wire logic [11:0] sample_temp,
  input  wire logic        ptr_wr,
  input  wire logic [7:0]  ptr_in,
  input  wire logic        rd_start,
  input  wire logic        rd_next,
  output logic             conv_start,
  output logic [7:0]       rd_data,
  output logic             charge_overflow_flag
);

  // ---------------------------------------------------------------------
  // Conversion timer
  // ---------------------------------------------------------------------
  logic [power_monitor_pkg::CONV_CNT_W-1:0] conv_cnt;
  logic [power_monitor_pkg::CONV_CNT_W-1:0] next_conv_cnt;
  logic [power_monitor_pkg::CONV_CNT_W-1:0] conv_len;
  logic                                     next_conv_start;

  always_comb begin
    conv_len = power_monitor_pkg::CONV_CNT_W'(
      power_monitor_pkg::CONV_TIME_US[conv_sel] * US_CYCLES);
    next_conv_start = 1'b0;
    next_conv_cnt   = conv_cnt - 1'b1;
    if (conv_cnt == '0) begin
      next_conv_start = 1'b1;
      next_conv_cnt   = conv_len - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      conv_cnt   <= '0;
      conv_start <= 1'b0;
    end else begin
      conv_cnt   <= next_conv_cnt;
      conv_start <= next_conv_start;
    end
  end

  // ---------------------------------------------------------------------
  // Averaging and result registers
  // ---------------------------------------------------------------------
  logic signed [power_monitor_pkg::SUM_W-1:0] sum_curr, next_sum_curr;
  logic signed [power_monitor_pkg::SUM_W-1:0] sum_bus, next_sum_bus;
  logic signed [power_monitor_pkg::SUM_W-1:0] tot_curr, tot_bus;
  logic signed [power_monitor_pkg::SUM_W-1:0] avg_curr, avg_bus;
  logic [power_monitor_pkg::AVG_CNT_W-1:0]    avg_cnt, next_avg_cnt;
  logic [3:0]                                 avg_shift;
  logic                                       avg_last;
  logic [15:0]                                current_result;
  logic [15:0]                                bus_voltage_result;
  logic [11:0]                                die_temperature_result;
  logic [23:0]                                power_result;
  logic [15:0]                                next_current, next_bus;
  logic [11:0]                                next_temp;
  logic [23:0]                                next_power;
  logic [15:0]                                curr_mag;
  logic [31:0]                                prod;
  logic                                       res_tick, next_res_tick;

  always_comb begin
    avg_shift = power_monitor_pkg::AVG_SHIFT[avg_sel];
    avg_last  = avg_cnt == power_monitor_pkg::AVG_CNT_W'(
      (1 << avg_shift) - 1);
    tot_curr = sum_curr + {{10{sample_current[15]}}, sample_current};
    tot_bus  = sum_bus + {{10{sample_bus[15]}}, sample_bus};
    avg_curr = tot_curr >>> avg_shift;
    avg_bus  = tot_bus >>> avg_shift;
    next_sum_curr = sum_curr;
    next_sum_bus  = sum_bus;
    next_avg_cnt  = avg_cnt;
    next_current  = current_result;
    next_bus      = bus_voltage_result;
    next_temp     = die_temperature_result;
    next_power    = power_result;
    next_res_tick = 1'b0;
    // Negative bus readings are noise about zero and read as zero
    next_bus = avg_bus[power_monitor_pkg::SUM_W-1] ? '0 :
               avg_bus[15:0];
    curr_mag = avg_curr[15] ? 16'(-avg_curr[15:0]) : avg_curr[15:0];
    prod = 32'(curr_mag) * 32'(next_bus);
    if (!sample_valid)
      next_bus = bus_voltage_result;
    if (sample_valid) begin
      if (avg_last) begin
        next_sum_curr = '0;
        next_sum_bus  = '0;
        next_avg_cnt  = '0;
        next_current  = avg_curr[15:0];
        next_temp     = sample_temp;
        next_power    = prod[power_monitor_pkg::POWER_SHIFT +: 24];
        next_res_tick = 1'b1;
      end else begin
        next_sum_curr = tot_curr;
        next_sum_bus  = tot_bus;
        next_avg_cnt  = avg_cnt + 1'b1;
        next_bus      = bus_voltage_result;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sum_curr               <= '0;
      sum_bus                <= '0;
      avg_cnt                <= '0;
      current_result         <= power_monitor_pkg::RESULT_RST;
      bus_voltage_result     <= power_monitor_pkg::RESULT_RST;
      die_temperature_result <= power_monitor_pkg::RESULT_RST[11:0];
      power_result           <= power_monitor_pkg::POWER_RST;
      res_tick               <= 1'b0;
    end else begin
      sum_curr               <= next_sum_curr;
      sum_bus                <= next_sum_bus;
      avg_cnt                <= next_avg_cnt;
      current_result         <= next_current;
      bus_voltage_result     <= next_bus;
      die_temperature_result <= next_temp;
      power_result           <= next_power;
      res_tick               <= next_res_tick;
    end
  end

  // ---------------------------------------------------------------------
  // Energy and charge accumulators
  // ---------------------------------------------------------------------
  logic [39:0] energy_accumulator, next_energy;
  logic [39:0] charge_accumulator, next_charge;
  logic [39:0] curr_ext, charge_sum;
  logic        charge_ovf;
  logic        next_flag;

  always_comb begin
    curr_ext   = {{24{current_result[15]}}, current_result};
    charge_sum = charge_accumulator + curr_ext;
    charge_ovf = res_tick
      && (charge_accumulator[39] == curr_ext[39])
      && (charge_sum[39] != charge_accumulator[39]);
    next_energy = energy_accumulator;
    next_charge = charge_accumulator;
    next_flag   = charge_overflow_flag;
    if (res_tick) begin
      // Plain 40-bit add drops the carry, so energy rolls to zero
      next_energy = energy_accumulator
                    + {16'h0000, power_result};
      next_charge = charge_sum;
    end
    if (accumulator_clear_bit) begin
      next_energy = power_monitor_pkg::ACC_RST;
      next_charge = power_monitor_pkg::ACC_RST;
      next_flag   = 1'b0;
    end
    // An overflow in the clearing cycle still raises the flag
    if (charge_ovf)
      next_flag = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      energy_accumulator   <= power_monitor_pkg::ACC_RST;
      charge_accumulator   <= power_monitor_pkg::ACC_RST;
      charge_overflow_flag <= 1'b0;
    end else begin
      energy_accumulator   <= next_energy;
      charge_accumulator   <= next_charge;
      charge_overflow_flag <= next_flag;
    end
  end

  // ---------------------------------------------------------------------
  // Pointer and byte read-out
  // ---------------------------------------------------------------------
  logic [7:0]  ptr, next_ptr;
  logic [39:0] shreg, next_shreg;
  logic [39:0] sel_word;
  logic [7:0]  next_rd_data;

  always_comb begin
    // Selected register, left-justified so its top byte leaves first
    case (ptr)
      power_monitor_pkg::PTR_BUS:    sel_word = {bus_voltage_result, 24'h0};
      power_monitor_pkg::PTR_TEMP:
        sel_word = {{4{die_temperature_result[11]}},
                    die_temperature_result, 24'h0};
      power_monitor_pkg::PTR_CURR:   sel_word = {current_result, 24'h0};
      power_monitor_pkg::PTR_POWER:  sel_word = {power_result, 16'h0};
      power_monitor_pkg::PTR_ENERGY: sel_word = energy_accumulator;
      power_monitor_pkg::PTR_CHARGE: sel_word = charge_accumulator;
      default:                       sel_word = '0;
    endcase
    next_ptr     = ptr_wr ? ptr_in : ptr;
    next_shreg   = shreg;
    next_rd_data = rd_data;
    if (rd_start) begin
      next_rd_data = sel_word[39:32];
      next_shreg   = {sel_word[31:0], 8'h00};
    end else if (rd_next) begin
      next_rd_data = shreg[39:32];
      next_shreg   = {shreg[31:0], 8'h00};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr     <= power_monitor_pkg::PTR_RST;
      shreg   <= '0;
      rd_data <= 8'h00;
    end else begin
      ptr     <= next_ptr;
      shreg   <= next_shreg;
      rd_data <= next_rd_data;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_avg_done;
    sample_valid && avg_last;
  endsequence

  sequence s_result_then_acc;
    res_tick ##1 ($past(accumulator_clear_bit) ||
                  energy_accumulator == $past(energy_accumulator)
                  + {16'h0000, $past(power_result)});
  endsequence

  a_ptr_hold: assert property (
    !ptr_wr |=> ptr == $past(ptr))
    else $error("pointer changed without a write");

  a_ptr_load: assert property (
    ptr_wr |=> ptr == $past(ptr_in))
    else $error("pointer not loaded");

  a_msb_first: assert property (
    rd_start && ptr == power_monitor_pkg::PTR_CURR
    |=> rd_data == $past(current_result[15:8]))
    else $error("current read did not start with top byte");

  a_bus_positive: assert property (
    !bus_voltage_result[15])
    else $error("bus voltage result negative");

  a_energy_clear: assert property (
    accumulator_clear_bit |=> energy_accumulator == '0)
    else $error("energy not cleared");

  a_avg_feeds_acc: assert property (
    s_avg_done |=> s_result_then_acc)
    else $error("averaged result not accumulated");

  a_flag_set: assert property (
    charge_ovf |=> charge_overflow_flag)
    else $error("charge overflow flag not raised");

  a_flag_sticky: assert property (
    charge_overflow_flag && !accumulator_clear_bit
    |=> charge_overflow_flag)
    else $error("charge overflow flag dropped");

  a_charge_clear: assert property (
    accumulator_clear_bit |=> charge_accumulator == '0)
    else $error("charge not cleared");

  a_flag_clear: assert property (
    accumulator_clear_bit && !charge_ovf |=> !charge_overflow_flag)
    else $error("charge overflow flag not cleared");

  a_conv_pulse: assert property (
    conv_start |=> !conv_start)
    else $error("conversion pulse too long");

endmodule : power_monitor_results

//--- core/power_monitor_pkg.sv
package power_monitor_pkg;

  // ---------------------------------------------------------------------
  // Register pointers
  // ---------------------------------------------------------------------
  localparam logic [7:0] PTR_BUS    = 8'h05;
  localparam logic [7:0] PTR_TEMP   = 8'h06;
  localparam logic [7:0] PTR_CURR   = 8'h07;
  localparam logic [7:0] PTR_POWER  = 8'h08;
  localparam logic [7:0] PTR_ENERGY = 8'h09;
  localparam logic [7:0] PTR_CHARGE = 8'h0A;
  localparam logic [7:0] PTR_RST    = 8'h07;

  // ---------------------------------------------------------------------
  // Field widths and scaling
  // ---------------------------------------------------------------------
  localparam int CURR_W  = 16;
  localparam int BUS_W   = 16;
  localparam int TEMP_W  = 12;
  localparam int POWER_W = 24;
  localparam int ACC_W   = 40;
  localparam int SUM_W   = 26;
  localparam int BYTE_W  = 8;
  // Current LSB times bus LSB is 1/64 of the power LSB
  localparam int POWER_SHIFT = 6;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [23:0] POWER_RST  = 24'h000000;
  localparam logic [39:0] ACC_RST    = 40'h0000000000;

  // ---------------------------------------------------------------------
  // Conversion timing and averaging
  // ---------------------------------------------------------------------
  localparam int CLK_FREQ_HZ   = 40_000_000;
  localparam int HZ_PER_MHZ    = 1_000_000;
  localparam int CYCLES_PER_US = CLK_FREQ_HZ / HZ_PER_MHZ;
  localparam int CONV_CNT_W    = 24;
  localparam int AVG_CNT_W     = 11;
  localparam int unsigned CONV_TIME_US [8] =
    '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  // Averaging counts 1,4,16,64,128,256,512,1024 as powers of two
  localparam logic [3:0] AVG_SHIFT [8] =
    '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};

endpackage : power_monitor_pkg

//--- tb/reg_reader.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------
// Serial controller model: sets the pointer and pulls result bytes
// ---------------------------------------------------------------------
module reg_reader (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output logic            ptr_wr,
  output logic [7:0]      ptr_in,
  output logic            rd_start,
  output logic            rd_next
);
  initial begin
    ptr_wr   = 1'b0;
    ptr_in   = 8'hFF;
    rd_start = 1'b0;
    rd_next  = 1'b0;
  end

  task automatic read_reg(input logic [7:0] ptr, input int nbytes,
                          input bit set_ptr, output logic [39:0] val);
    int i;
    val = 40'h0000000000;
    @(negedge clk);
    // Pointer write skipped when set_ptr is clear, so the held pointer is read
    if (set_ptr) begin
      ptr_wr = 1'b1;
      ptr_in = ptr;
      @(negedge clk);
      ptr_wr = 1'b0;
      ptr_in = ~ptr;
    end
    rd_start = 1'b1;
    for (i = 0; i < nbytes; i++) begin
      @(negedge clk);
      rd_start = 1'b0;
      rd_next  = (i < nbytes - 1);
      val      = {val[31:0], rd_data};
    end
  endtask : read_reg
endmodule : reg_reader

//--- tb/testbench.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  logic clk = 1'b0, rst = 1'b1, accumulator_clear_bit = 1'b0;
  logic [2:0] conv_sel = 3'h0, avg_sel = 3'h0;
  logic sample_valid = 1'b0, ptr_wr, rd_start, rd_next;
  logic [15:0] sample_current = 16'h0000, sample_bus = 16'h0000;
  logic [11:0] sample_temp = 12'h000;
  logic [7:0] ptr_in, rd_data;
  logic conv_start, charge_overflow_flag;
  logic [39:0] got, e_acc, c_acc;
  logic [15:0] ci, cv;
  logic [11:0] ct;
  int error_cnt = 0, check_count = 0, seed = 32'hfafa, n, k;

  always #12.5 clk = ~clk;

  power_monitor_results #(.US_CYCLES(1)) power_monitor_results_inst (
    .clk(clk), .rst(rst), .conv_sel(conv_sel), .avg_sel(avg_sel),
    .accumulator_clear_bit(accumulator_clear_bit),
    .sample_valid(sample_valid), .sample_current(sample_current),
    .sample_bus(sample_bus), .sample_temp(sample_temp), .ptr_wr(ptr_wr),
    .ptr_in(ptr_in), .rd_start(rd_start), .rd_next(rd_next),
    .conv_start(conv_start), .rd_data(rd_data),
    .charge_overflow_flag(charge_overflow_flag));

  reg_reader reg_reader_inst (.clk(clk), .rd_data(rd_data),
    .ptr_wr(ptr_wr), .ptr_in(ptr_in), .rd_start(rd_start),
    .rd_next(rd_next));

  function automatic logic [23:0] exp_pow(input logic [15:0] i, v);
    logic [15:0] mag;
    logic [31:0] prod;
    mag  = i[15] ? ~i + 16'h0001 : i;
    prod = 32'(mag) * 32'(v[15] ? 16'h0000 : v);
    return prod[29:6];
  endfunction : exp_pow

  task automatic put(input logic [15:0] i, v, input logic [11:0] t);
    @(negedge clk);
    sample_valid   = 1'b1;
    sample_current = i;
    sample_bus     = v;
    sample_temp    = t;
  endtask : put

  // Drop the sample strobe and let results and accumulators settle
  task automatic settle;
    @(negedge clk);
    sample_valid   = 1'b0;
    sample_current = ~sample_current;
    repeat (3) @(negedge clk);
  endtask : settle

  task automatic chk_reg(input logic [7:0] p, input int nb, input bit sp,
                         input logic [39:0] e);
    reg_reader_inst.read_reg(p, nb, sp, got);
    `CHK(got, e)
  endtask : chk_reg

  task automatic clear_acc;
    @(negedge clk);
    accumulator_clear_bit = 1'b1;
    @(negedge clk);
    accumulator_clear_bit = 1'b0;
  endtask : clear_acc

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    end_of_test;
  end

  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk_reg(8'h07, 2, 0, 40'h0);
    chk_reg(8'h03, 2, 1, 40'h0);
    clear_acc;
    e_acc = 40'h0;
    c_acc = 40'h0;
    // ---------------------------------------------------------------
    // Single-sample results, random with sign corners
    // ---------------------------------------------------------------
    for (n = 0; n < 8; n++) begin
      ci = (n == 0) ? 16'h8000 : 16'($random(seed));
      cv = (n == 1) ? 16'hFFF0 : (16'($random(seed)) & 16'h7FFF);
      ct = (n == 2) ? 12'h800 : 12'($random(seed));
      put(ci, cv, ct);
      settle;
      e_acc += exp_pow(ci, cv);
      c_acc += {{24{ci[15]}}, ci};
      chk_reg(8'h07, 2, 1, ci);
      chk_reg(8'h05, 2, 1, cv[15] ? 16'h0 : cv);
      chk_reg(8'h06, 2, 1, {{4{ct[11]}}, ct});
      chk_reg(8'h08, 3, 1, exp_pow(ci, cv));
    end
    chk_reg(8'h09, 5, 1, e_acc);
    chk_reg(8'h0A, 5, 1, c_acc);
    chk_reg(8'h0A, 5, 0, c_acc);
    `CHK(charge_overflow_flag, 1'b0)
    clear_acc;
    chk_reg(8'h09, 5, 1, 40'h0);
    chk_reg(8'h0A, 5, 1, 40'h0);
    // ---------------------------------------------------------------
    // Every averaging count and conversion time
    // ---------------------------------------------------------------
    for (k = 0; k < 8; k++) begin
      avg_sel  = k[2:0];
      conv_sel = k[2:0];
      ci = 16'h0100 + k[15:0];
      repeat (1 << power_monitor_pkg::AVG_SHIFT[k]) put(ci, 16'h0400, 12'h0);
      settle;
      chk_reg(8'h07, 2, 1, ci);
      n = 0;
      while (!conv_start && n < 5000) begin
        @(negedge clk);
        n++;
      end
      n = 0;
      @(negedge clk);
      while (!conv_start && n < 5000) begin
        @(negedge clk);
        n++;
      end
      `CHK(n + 1, power_monitor_pkg::CONV_TIME_US[k])
    end
    // ---------------------------------------------------------------
    // Energy rolls over past 40 bits
    // ---------------------------------------------------------------
    avg_sel = 3'h0;
    clear_acc;
    repeat (65540) put(16'h8000, 16'h7FFF, 12'h0);
    settle;
    e_acc = 40'(64'(65540) * 64'(exp_pow(16'h8000, 16'h7FFF)));
    chk_reg(8'h09, 5, 1, e_acc);
    chk_reg(8'h0A, 5, 1, -(40'd65540 * 40'd32768));
    `CHK(charge_overflow_flag, 1'b0)
    end_of_test;
  end
endmodule : testbench
